// >>> hw/touch_panel_pkg.sv
package touch_panel_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [31:0] SAMPLE_INTERVAL_IDX   = 32'h0b000126;
  localparam logic [31:0] SETTLE_ADC_CLOCK_IDX  = 32'h0b000128;
  localparam logic [31:0] SCAN_COMMAND_IDX      = 32'h0b00012a;
  localparam logic [31:0] INTERVAL_READBACK_IDX = 32'h0b00013c;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int INTERVAL_W       = 11;
  localparam int SETTLE_LSB       = 0;
  localparam int DIVIDER_LSB      = 4;
  localparam int MODEL_BIT        = 8;
  localparam int CMD_LSB          = 0;
  localparam int PATTERN_LSB      = 4;
  localparam int SETTLE_EN_BIT    = 9;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [10:0] SAMPLE_INTERVAL_RST = 11'h0a7;
  localparam logic [8:0]  SETTLE_ADC_RST      = 9'h077;
  localparam logic [9:0]  SCAN_COMMAND_RST    = 10'h1be;

  // ----------------------------------------------------------------
  // Encodings and timing
  // ----------------------------------------------------------------
  localparam logic [3:0] CMD_POWER_DOWN = 4'he;
  localparam int         CLK_PERIOD_NS  = 25;
  localparam int         TICK_US        = 30;
  localparam int         TICK_CYCLES    = (TICK_US * 1000) / CLK_PERIOD_NS;
  localparam int         SYNC_STAGES    = 2;

endpackage

// >>> hw/touch_panel_unit.sv
// Design decision made here: the plain strobed port.
`timescale 1ns/10ps
// Overview of operation
// - Successive coordinate sample sets are spaced by the 11-bit interval setting times 30 us.
// - The interval is set in 30 us steps from zero up to 61410 us.
// - A programmed interval shorter than one coordinate transfer stretches to that transfer time.
// - Reserved register bits read as zero and software writes zero to them.
// - The converter-model bit picks a 10-bit converter when one and a 12-bit converter when zero.
// - The converter clock is the 16.58 MHz source divided by four times the divider field plus two.
// - After panel voltage is applied the unit waits the settling field times 30 us, 0 to 450 us.
// - The settling-wait enable applies that wait when one and treats it as zero when cleared.
// - With the 10-bit converter selected a power-down converter command is ignored.
// - A countdown loaded from the interval setting is readable live through an 11-bit register.
module touch_panel_unit
  import touch_panel_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_b_i,
  input  wire logic        unit_reset_i,
  // Register port
  input  wire logic [31:0] addr_i,
  input  wire logic [15:0] wr_data_i,
  input  wire logic        wr_en_i,
  input  wire logic        rd_en_i,
  output logic      [15:0] rd_data_o,
  // Scan sequencer side
  input  wire logic        seq_run_i,
  input  wire logic        transfer_busy_i,
  input  wire logic        panel_drive_applied_i,
  output logic             sample_start_o,
  output logic             settle_done_o,
  output logic             converter_model_o,
  output logic      [3:0]  converter_command_o,
  output logic      [4:0]  panel_pin_pattern_o,
  // Converter clock
  input  wire logic        conv_src_clk_i,
  output logic             converter_clock_o
);

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [10:0] interval_setting_reg;
  logic [8:0]  settle_adc_reg;
  logic [9:0]  scan_command_reg;
  logic [10:0] interval_live_count_reg;

  logic        hit_interval;
  logic        hit_settle;
  logic        hit_command;
  logic        hit_readback;
  logic [3:0]  settle_field;
  logic [3:0]  converter_clock_divider;
  logic        settle_wait_enable;
  logic [3:0]  cmd_next;

  // Index compare on the word address; low two bits are the byte lane
  assign hit_interval = (addr_i[31:2] == SAMPLE_INTERVAL_IDX[29:0]) && (addr_i[1:0] == 2'h0);
  assign hit_settle   = (addr_i[31:2] == SETTLE_ADC_CLOCK_IDX[29:0]) && (addr_i[1:0] == 2'h0);
  assign hit_command  = (addr_i[31:2] == SCAN_COMMAND_IDX[29:0]) && (addr_i[1:0] == 2'h0);
  assign hit_readback = (addr_i[31:2] == INTERVAL_READBACK_IDX[29:0]) && (addr_i[1:0] == 2'h0);

  assign settle_field            = settle_adc_reg[SETTLE_LSB +: 4];
  assign converter_clock_divider = settle_adc_reg[DIVIDER_LSB +: 4];
  assign converter_model_o       = settle_adc_reg[MODEL_BIT];
  assign settle_wait_enable      = scan_command_reg[SETTLE_EN_BIT];
  assign converter_command_o     = scan_command_reg[CMD_LSB +: 4];
  assign panel_pin_pattern_o     = scan_command_reg[PATTERN_LSB +: 5];

  // The 10-bit part has no power-down, so that code keeps the old command
  always_comb begin
    if (converter_model_o && (wr_data_i[CMD_LSB +: 4] == CMD_POWER_DOWN)) begin
      cmd_next = scan_command_reg[CMD_LSB +: 4];
    end else begin
      cmd_next = wr_data_i[CMD_LSB +: 4];
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      interval_setting_reg <= SAMPLE_INTERVAL_RST;
    end else if (unit_reset_i) begin
      interval_setting_reg <= SAMPLE_INTERVAL_RST;
    end else if (wr_en_i && hit_interval) begin
      interval_setting_reg <= wr_data_i[INTERVAL_W-1:0];
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      settle_adc_reg <= SETTLE_ADC_RST;
    end else if (unit_reset_i) begin
      settle_adc_reg <= SETTLE_ADC_RST;
    end else if (wr_en_i && hit_settle) begin
      settle_adc_reg <= wr_data_i[8:0];
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      scan_command_reg <= SCAN_COMMAND_RST;
    end else if (unit_reset_i) begin
      scan_command_reg <= SCAN_COMMAND_RST;
    end else if (wr_en_i && hit_command) begin
      scan_command_reg <= {wr_data_i[SETTLE_EN_BIT:PATTERN_LSB], cmd_next};
    end
  end

  // Read data stand one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_data_o <= 16'h0000;
    end else if (rd_en_i) begin
      if (hit_interval) begin
        rd_data_o <= {5'h00, interval_setting_reg};
      end else if (hit_settle) begin
        rd_data_o <= {7'h00, settle_adc_reg};
      end else if (hit_command) begin
        rd_data_o <= {6'h00, scan_command_reg};
      end else if (hit_readback) begin
        rd_data_o <= {5'h00, interval_live_count_reg};
      end else begin
        rd_data_o <= 16'h0000;
      end
    end else begin
      rd_data_o <= 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // 30 us time base
  // ----------------------------------------------------------------
  localparam logic [10:0] TICK_LAST = 11'(TICK_CYCLES - 1);
  logic [10:0] prescale_reg;
  logic        tick;

  assign tick = (prescale_reg == TICK_LAST);

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prescale_reg <= 11'h000;
    end else if (unit_reset_i || tick) begin
      prescale_reg <= 11'h000;
    end else begin
      prescale_reg <= prescale_reg + 11'h001;
    end
  end

  // ----------------------------------------------------------------
  // Sampling interval countdown
  // ----------------------------------------------------------------
  // A new set starts only when the count is spent and the previous transfer
  // is over, so a short interval stretches to the transfer time by itself.
  // A written setting restarts the count at once; otherwise the slow default
  // left by reset would hold off the new setting for up to 5010 us.
  logic fire;
  logic interval_write;

  assign fire           = seq_run_i && (interval_live_count_reg == 11'h000) && !transfer_busy_i;
  assign sample_start_o = fire;
  assign interval_write = wr_en_i && hit_interval;

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      interval_live_count_reg <= SAMPLE_INTERVAL_RST;
    end else if (unit_reset_i) begin
      interval_live_count_reg <= SAMPLE_INTERVAL_RST;
    end else if (interval_write) begin
      interval_live_count_reg <= wr_data_i[INTERVAL_W-1:0];
    end else if (fire) begin
      interval_live_count_reg <= interval_setting_reg;
    end else if (tick && (interval_live_count_reg != 11'h000)) begin
      interval_live_count_reg <= interval_live_count_reg - 11'h001;
    end
  end

  // ----------------------------------------------------------------
  // Panel voltage settling wait
  // ----------------------------------------------------------------
  logic [3:0] settle_count_reg;
  logic       settle_active_reg;
  logic       settle_done_reg;

  assign settle_done_o = settle_done_reg;

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      settle_count_reg  <= 4'h0;
      settle_active_reg <= 1'b0;
      settle_done_reg   <= 1'b0;
    end else if (unit_reset_i) begin
      settle_count_reg  <= 4'h0;
      settle_active_reg <= 1'b0;
      settle_done_reg   <= 1'b0;
    end else begin
      settle_done_reg <= 1'b0;
      if (panel_drive_applied_i) begin
        settle_count_reg  <= settle_wait_enable ? settle_field : 4'h0;
        settle_active_reg <= 1'b1;
      end else if (settle_active_reg && (settle_count_reg == 4'h0)) begin
        settle_active_reg <= 1'b0;
        settle_done_reg   <= 1'b1;
      end else if (settle_active_reg && tick) begin
        settle_count_reg <= settle_count_reg - 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Converter clock divider
  // ----------------------------------------------------------------
  // Source pin is sampled twice before use; 40 MHz is over twice its rate.
  // Half period is 2*div+1 source edges, giving a divide by 4*div+2.
  logic [SYNC_STAGES-1:0] src_sync_reg;
  logic                   src_prev_reg;
  logic                   src_rise;
  logic [4:0]             half_last;
  logic [4:0]             half_count_reg;
  logic                   conv_clk_reg;

  assign src_rise          = src_sync_reg[SYNC_STAGES-1] && !src_prev_reg;
  assign half_last         = {converter_clock_divider, 1'b0};
  assign converter_clock_o = conv_clk_reg;

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      src_sync_reg <= '0;
      src_prev_reg <= 1'b0;
    end else begin
      src_sync_reg <= {src_sync_reg[SYNC_STAGES-2:0], conv_src_clk_i};
      src_prev_reg <= src_sync_reg[SYNC_STAGES-1];
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      half_count_reg <= 5'h00;
      conv_clk_reg   <= 1'b0;
    end else if (unit_reset_i) begin
      half_count_reg <= 5'h00;
      conv_clk_reg   <= 1'b0;
    end else if (src_rise) begin
      if (half_count_reg >= half_last) begin
        half_count_reg <= 5'h00;
        conv_clk_reg   <= !conv_clk_reg;
      end else begin
        half_count_reg <= half_count_reg + 5'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);

  interval_reload_a: assert property (sample_start_o && !interval_write && !unit_reset_i |=>
      interval_live_count_reg == $past(interval_setting_reg))
    else $error("interval count not reloaded on sample start");

  interval_write_a: assert property (interval_write && !unit_reset_i |=>
      interval_live_count_reg == $past(wr_data_i[INTERVAL_W-1:0]))
    else $error("interval count not loaded by a setting write");

  interval_step_a: assert property (tick && !fire && !interval_write && !unit_reset_i
      && interval_live_count_reg != 11'h000 |=>
      interval_live_count_reg == $past(interval_live_count_reg) - 11'h001)
    else $error("interval count did not step on tick");

  interval_hold_a: assert property (!tick && !fire && !interval_write && !unit_reset_i |=>
      $stable(interval_live_count_reg))
    else $error("interval count moved without a tick");

  busy_blocks_a: assert property (transfer_busy_i |-> !sample_start_o)
    else $error("sample started during a transfer");

  tick_period_a: assert property (tick && !unit_reset_i |=> !tick [*8])
    else $error("tick period too short");

  reserved_zero_a: assert property ($past(rd_en_i) && !hit_readback |-> rd_data_o[15:11] == 5'h00)
    else $error("reserved bits read nonzero");

  readback_live_a: assert property (rd_en_i && hit_readback |=>
      rd_data_o == {5'h00, $past(interval_live_count_reg)})
    else $error("readback does not show live count");

  power_down_drop_a: assert property (wr_en_i && hit_command && converter_model_o && !unit_reset_i
      && wr_data_i[3:0] == CMD_POWER_DOWN |=> $stable(converter_command_o))
    else $error("power-down accepted with 10-bit converter");

  settle_zero_a: assert property (panel_drive_applied_i && !settle_wait_enable && !unit_reset_i
      ##1 !panel_drive_applied_i && !unit_reset_i |=> settle_done_o)
    else $error("disabled settling wait not immediate");

  settle_load_a: assert property (panel_drive_applied_i && settle_wait_enable && !unit_reset_i |=>
      settle_count_reg == $past(settle_field))
    else $error("settling count not loaded from field");

  clock_toggle_a: assert property (src_rise && half_count_reg < half_last && !unit_reset_i |=>
      $stable(conv_clk_reg))
    else $error("converter clock toggled early");

  model_out_a: assert property (wr_en_i && hit_settle && !unit_reset_i |=>
      converter_model_o == $past(wr_data_i[MODEL_BIT]))
    else $error("converter model not taken from write");

endmodule // touch_panel_unit

// >>> testbench/adc_partner.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Converter side: source clock and converter clock span meter
// ----------------------------------------------------------------
module adc_partner (
  // Converter clock from the unit
  input  wire logic       converter_clock_i,
  // Source clock and measurement
  output logic            src_clk_o,
  output logic      [9:0] span_o
);
  logic       last_q = 1'b0;
  logic [9:0] cnt_q  = 10'h000;
  logic [1:0] tog_q  = 2'h0;

  // Free-running 16.58 MHz source, unrelated in phase to the system clock
  initial src_clk_o = 1'b0;
  always #30.16 src_clk_o = ~src_clk_o;

  // Span of four half periods in source edges; one edge of slack comes from the resync
  always @(posedge src_clk_o) begin
    cnt_q  <= cnt_q + 10'h001;
    last_q <= converter_clock_i;
    if (last_q !== converter_clock_i) begin
      tog_q <= tog_q + 2'h1;
      if (tog_q == 2'h3) begin
        span_o <= cnt_q + 10'h001;
        cnt_q  <= 10'h000;
      end
    end
  end
endmodule // adc_partner

// >>> testbench/touch_panel_unit_tb.sv
`timescale 1ns/10ps
module touch_panel_unit_tb;
  import touch_panel_pkg::*;
  logic        clk_sys_i = 1'b0;
  logic        rst_b_i, unit_reset_i, wr_en_i, rd_en_i, seq_run_i, transfer_busy_i, panel_drive_applied_i;
  logic [31:0] addr_i;
  logic [15:0] wr_data_i, rd_data_o, v, w;
  logic        sample_start_o, settle_done_o, converter_model_o, conv_src_clk_i, converter_clock_o;
  logic [3:0]  converter_command_o;
  logic [4:0]  panel_pin_pattern_o;
  logic [9:0]  span;
  int          error_cnt = 0, n_compared = 0, seed = 41660, starts = 0, n, d, m;
  logic [31:0] regs [4] = '{SAMPLE_INTERVAL_IDX, SETTLE_ADC_CLOCK_IDX, SCAN_COMMAND_IDX, INTERVAL_READBACK_IDX};
  logic [15:0] dflt [4] = '{16'h00a7, 16'h0077, 16'h01be, 16'h00a7};

  touch_panel_unit u_dut (.clk_sys_i, .rst_b_i, .unit_reset_i, .addr_i, .wr_data_i, .wr_en_i, .rd_en_i,
    .rd_data_o, .seq_run_i, .transfer_busy_i, .panel_drive_applied_i, .sample_start_o, .settle_done_o,
    .converter_model_o, .converter_command_o, .panel_pin_pattern_o, .conv_src_clk_i, .converter_clock_o);
  adc_partner u_adc (.converter_clock_i(converter_clock_o), .src_clk_o(conv_src_clk_i), .span_o(span));

  always #12.5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) if (sample_start_o === 1'b1) starts <= starts + 1;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function logic [31:0] ba(input logic [31:0] idx);
    return idx << 2;
  endfunction
  // Only the documented fields survive a write; the rest reads zero
  function logic [15:0] keep(input logic [31:0] idx, input logic [15:0] x);
    case (idx)
      SAMPLE_INTERVAL_IDX:  return x & 16'h07ff;
      SETTLE_ADC_CLOCK_IDX: return x & 16'h01ff;
      SCAN_COMMAND_IDX:     return x & 16'h03ff;
      default:              return 16'h0000;
    endcase
  endfunction
  task print_verdict();
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task check(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task wr(input logic [31:0] a, input logic [15:0] x);
    @(posedge clk_sys_i) begin wr_en_i <= 1'b1; addr_i <= a; wr_data_i <= x; end
    @(posedge clk_sys_i) wr_en_i <= 1'b0;
    // Outputs are looked at only once the write has settled
    @(negedge clk_sys_i);
  endtask
  task rd(input logic [31:0] a, output logic [15:0] x);
    @(posedge clk_sys_i) begin rd_en_i <= 1'b1; addr_i <= a; end
    @(posedge clk_sys_i) rd_en_i <= 1'b0;
    @(negedge clk_sys_i) x = rd_data_o;
  endtask
  task pulse();
    @(posedge clk_sys_i) panel_drive_applied_i <= 1'b1;
    @(posedge clk_sys_i) panel_drive_applied_i <= 1'b0;
  endtask
  // Cycles until the chosen output is seen high; running out is a failure
  task automatic wait_sig(input int sel, input int lim, output int k);
    k = 0;
    do begin
      @(negedge clk_sys_i);
      k++;
    end while (((sel != 0 ? settle_done_o : sample_start_o) !== 1'b1) && k < lim);
    if (k >= lim) begin
      error_cnt++;
      print_verdict();
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst_b_i, unit_reset_i, wr_en_i, rd_en_i, transfer_busy_i, panel_drive_applied_i} = '0;
    addr_i = '0;
    wr_data_i = '0;
    seq_run_i = 1'b1;
    repeat (2) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rd(ba(regs[i]), v);
      check(v, dflt[i]);
    end
    rd(ba(32'h0b00012c), v);
    check(v, 16'h0000);
    wr(ba(SAMPLE_INTERVAL_IDX), 16'h0123);
    @(posedge clk_sys_i) unit_reset_i <= 1'b1;
    @(posedge clk_sys_i) unit_reset_i <= 1'b0;
    rd(ba(SAMPLE_INTERVAL_IDX), v);
    check(v, 16'h00a7);
    // First pass sets every field bit except the converter-model bit; reserved bits are written as zero
    for (int i = 0; i < 6; i++) begin
      for (int j = 0; j < 3; j++) begin
        w = (i == 0) ? 16'hffff : 16'($random(seed));
        w = keep(regs[j], w);
        if (j == 1) begin
          w[8] = 1'b0;
          if (w[7:4] < 4'h2) w[7:4] = 4'h2;
        end
        wr(ba(regs[j]), w);
        rd(ba(regs[j]), v);
        check(v, keep(regs[j], w));
      end
    end
    wr(ba(SCAN_COMMAND_IDX), 16'h0035);
    wr(ba(SETTLE_ADC_CLOCK_IDX), 16'h0120);
    check(16'(converter_model_o), 16'h0001);
    wr(ba(SCAN_COMMAND_IDX), 16'h02ae);
    check(16'(converter_command_o), 16'h0005);
    check(16'(panel_pin_pattern_o), 16'h000a);
    wr(ba(SETTLE_ADC_CLOCK_IDX), 16'h0020);
    check(16'(converter_model_o), 16'h0000);
    wr(ba(SCAN_COMMAND_IDX), 16'h02ae);
    check(16'(converter_command_o), 16'h000e);
    for (int k = 0; k < 3; k++) begin
      d = (k == 0) ? 2 : (k == 1) ? 15 : 2 + (($random(seed) & 32'h7fffffff) % 14);
      wr(ba(SETTLE_ADC_CLOCK_IDX), 16'(d << 4));
      repeat (1500) @(posedge clk_sys_i);
      check(16'(span >= 8 * d + 3 && span <= 8 * d + 5), 16'h0001);
    end
    wr(ba(SCAN_COMMAND_IDX), 16'h01be);
    wr(ba(SETTLE_ADC_CLOCK_IDX), 16'h0025);
    pulse();
    wait_sig(1, 50, n);
    check(16'(n >= 1 && n <= 3), 16'h0001);
    wr(ba(SCAN_COMMAND_IDX), 16'h03be);
    for (int k = 0; k < 3; k++) begin
      m = (k == 0) ? 0 : (k == 1) ? 15 : 1 + (($random(seed) & 32'h7fffffff) % 14);
      wr(ba(SETTLE_ADC_CLOCK_IDX), 16'(32'h20 | m));
      pulse();
      wait_sig(1, 20000, n);
      check(16'(n >= (m - 1) * TICK_CYCLES && n <= m * TICK_CYCLES + 4), 16'h0001);
    end
    // A setting write restarts the countdown at once
    wr(ba(SAMPLE_INTERVAL_IDX), 16'h0003);
    wait_sig(0, 5000, n);
    wait_sig(0, 5000, n);
    check(16'(n), 16'(3 * TICK_CYCLES));
    rd(ba(INTERVAL_READBACK_IDX), v);
    check(v, 16'h0003);
    @(posedge clk_sys_i) transfer_busy_i <= 1'b1;
    n = starts;
    repeat (4000) @(posedge clk_sys_i);
    check(16'(starts == n), 16'h0001);
    rd(ba(INTERVAL_READBACK_IDX), v);
    check(v, 16'h0000);
    @(posedge clk_sys_i) begin transfer_busy_i <= 1'b0; seq_run_i <= 1'b0; end
    n = starts;
    repeat (20) @(posedge clk_sys_i);
    check(16'(starts == n), 16'h0001);
    @(posedge clk_sys_i) seq_run_i <= 1'b1;
    wait_sig(0, 4, n);
    check(16'(n <= 2), 16'h0001);
    print_verdict();
  end
endmodule // touch_panel_unit_tb
